// ---- bench/tspc_dev_model.sv ----
// Behavioural model of the serial port device on the host's device bus
`default_nettype none
module tspc_dev_model import tspc_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [tspc_pkg::DEV_AW-1:0] dev_addr,
   input wire logic [tspc_pkg::DW-1:0] dev_wdata,
   input wire logic dev_wr,
   input wire logic dev_rd,
   output logic [tspc_pkg::DW-1:0] dev_rdata,
   input wire logic sclk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mode_q, clk_q, dir_q, lat_q, tx_q, sh_q;
   logic sclk_q;
   int cnt, ecnt, starts, viol;
   // Registers, transfer progress and enable reset; bad software accesses counted
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_q <= 8'h00;
         clk_q <= 8'h00;
         dir_q <= 8'hFF;
         lat_q <= 8'h00;
         tx_q <= 8'h00;
         sh_q <= 8'h00;
         sclk_q <= 1'b0;
         {cnt, ecnt, starts, viol} <= '0;
         dev_rdata <= 8'h00;
      end else begin
         sclk_q <= sclk;
         dev_rdata <= ~dev_rdata; // Idle bus never repeats a stale value
         if (sclk != sclk_q) ecnt <= ecnt + 1;
         if (mode_q[0]) begin
            cnt <= cnt + 1;
            if (clk_q[2:0] == 3'h7 ? ecnt == 16 : cnt == 15) begin
               mode_q[0] <= 1'b0;
               sh_q <= ~tx_q; // Far side answers the complement
            end
         end
         if (dev_rd && dev_addr == MODE_ADDR) dev_rdata <= mode_q;
         if (dev_rd && dev_addr == SHIFT_ADDR) begin
            dev_rdata <= sh_q;
            if (mode_q[7] && !mode_q[6]) begin
               mode_q[0] <= 1'b1;
               {cnt, ecnt} <= '0;
               starts <= starts + 1;
            end
         end
         if (dev_wr) begin
            if (mode_q[0] && dev_addr != MODE_ADDR) viol <= viol + 1;
            case (dev_addr)
               MODE_ADDR: begin
                  if (dev_wdata[5] || (mode_q[0] && dev_wdata[6:4] != mode_q[6:4])) viol <= viol + 1;
                  mode_q <= {dev_wdata[7:6], 1'b0, dev_wdata[4], 3'b000, mode_q[0]};
                  if (!dev_wdata[7]) begin
                     mode_q[0] <= 1'b0;
                     sh_q <= 8'h00;
                  end
               end
               CLKSEL_ADDR: begin
                  if (mode_q[7]) viol <= viol + 1;
                  clk_q <= dev_wdata;
               end
               DIR_ADDR: dir_q <= dev_wdata;
               LATCH_ADDR: lat_q <= dev_wdata;
               TXBUF_ADDR: begin
                  tx_q <= dev_wdata;
                  if (mode_q[7] && mode_q[6]) begin
                     mode_q[0] <= 1'b1;
                     {cnt, ecnt} <= '0;
                     starts <= starts + 1;
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule // tspc_dev_model
`default_nettype wire

// ---- bench/tspc_host_bench.sv ----
// Self-checking bench for the serial port host controller
`default_nettype none
module tspc_host_bench import tspc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, hw = 1'b0, hr = 1'b0, dstop = 1'b0, dw, dr, sclk, oe;
   logic [2:0] ha = 3'h0;
   logic [7:0] hwd = 8'h00, hrd, dwd, drd, st, tx, v;
   logic [15:0] da;
   int err_count = 0, cmp_count = 0, n;
   always #12.5 clk_sys = ~clk_sys;
   // Faster peripheral clock so the lowest divider is out of range
   tspc_host #(.PRS_HZ(20_000_000)) dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .host_addr(ha),
      .host_wdata(hwd), .host_wr(hw), .host_rd(hr), .host_rdata(hrd), .dev_addr(da), .dev_wdata(dwd),
      .dev_wr(dw), .dev_rd(dr), .dev_rdata(drd), .dev_stop(dstop), .slv_sclk(sclk), .slv_sclk_oe(oe));
   tspc_dev_model m (.clk_sys(clk_sys), .rst(rst), .dev_addr(da), .dev_wdata(dwd), .dev_wr(dw),
      .dev_rd(dr), .dev_rdata(drd), .sclk(sclk));
   task automatic results();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      ha <= a;
      hwd <= d;
      hw <= 1'b1;
      @(posedge clk_sys);
      hw <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      ha <= a;
      hr <= 1'b1;
      @(posedge clk_sys);
      hr <= 1'b0;
      #1 d = hrd;
   endtask
   // Poll status under a bound, then clear the sticky flags
   task automatic wait_done(output logic [7:0] s);
      int i;
      for (i = 0; i < 500; i++) begin
         rd(H_STAT, s);
         if (s[ST_DONE] === 1'b1) break;
      end
      if (i == 500) begin
         err_count++;
         $display("Error %0t: wait for done timed out", $time);
         results();
      end
      wr(H_STAT, 8'h06);
   endtask
   task automatic cfg(input logic [7:0] c);
      wr(H_CFG, c);
      wr(H_CMD, 8'h01);
      wait_done(st);
      chk(m.mode_q, {1'b1, c[CFG_TRMD], 1'b0, c[CFG_LSB], 4'h0});
      chk(m.clk_q, {3'b000, c[CFG_CKP], c[CFG_DAP], c[6:4]});
      chk({m.dir_q[2:0], m.lat_q[2:0]}, {~c[0], 1'b1, c[6:4] == 3'h7, 3'b001});
      chk({6'h00, st[ST_CFGD], oe}, {6'h00, 1'b1, c[6:4] == 3'h7});
   endtask
   // Send one byte and compare the received byte with the expected byte given
   task automatic xfer(input logic [7:0] t, input logic [7:0] exp);
      wr(H_TX, t);
      wr(H_CMD, 8'h02);
      wait_done(st);
      rd(H_RX, v);
      chk(v, exp);
      chk({7'h00, m.mode_q[0]}, 8'h00);
   endtask
   initial begin
      n = $urandom(32'h6f29);
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      chk(m.mode_q, 8'h00);
      chk(m.clk_q, 8'h00);
      chk(m.dir_q, 8'hFF);
      rd(3'h6, v);
      chk(v, 8'h00);
      $display("Test reset done");
      wr(H_CFG, 8'h01);
      wr(H_CMD, 8'h01);
      repeat (10) @(posedge clk_sys);
      rd(H_STAT, st);
      chk({7'h00, st[ST_ERR]}, 8'h01);
      chk(m.mode_q, 8'h00);
      wr(H_STAT, 8'h06);
      $display("Test speed refusal done");
      cfg({1'b0, 3'h1, 2'($urandom), 1'($urandom), 1'b1});
      for (int i = 0; i < 3; i++) begin
         tx = 8'($urandom);
         xfer(tx, ~tx);
      end
      wr(H_TX, tx);
      wr(H_CMD, 8'h02);
      wr(H_CFG, 8'h00);
      wait_done(st);
      chk({7'h00, st[ST_ERR]}, 8'h01);
      $display("Test master transfers done");
      cfg(8'h20);
      // Disable write of the set-up cleared the shift register, so the first read returns zero
      xfer(8'h00, 8'h00);
      xfer(8'h00, ~tx);
      $display("Test receive mode done");
      wr(H_DIV, 8'h03);
      tx = 8'($urandom);
      cfg(8'h71);
      xfer(tx, ~tx);
      chk(8'(m.ecnt), 8'h10);
      $display("Test slave transfer done");
      dstop <= 1'b1;
      n = m.starts;
      repeat (6) @(posedge clk_sys);
      wr(H_CMD, 8'h02);
      repeat (10) @(posedge clk_sys);
      rd(H_STAT, st);
      chk({6'h00, st[ST_STOP], st[ST_ERR]}, 8'h03);
      chk(8'(m.starts - n), 8'h00);
      dstop <= 1'b0;
      wr(H_STAT, 8'h06);
      wr(H_CMD, 8'h04);
      wait_done(st);
      chk(m.mode_q, 8'h00);
      chk(m.clk_q, 8'h00);
      chk({7'h00, oe}, 8'h00);
      chk(m.sh_q, 8'h00);
      chk(8'(m.viol), 8'h00);
      $display("Test stop and release done");
      results();
   end
endmodule // tspc_host_bench
`default_nettype wire

// ---- core/tspc_host.sv ----
// Host controller that programs and runs the three-wire serial port
// Contract
// - Software never changes txrx mode bit while busy.
// - Software never changes first-bit order while busy.
// - Software always writes mode bit 5 as zero.
// - Software keeps the serial clock at or below 5 MHz.
// - Software never writes clock select while enable is 1.
// - No slave communication on external clock during STOP.
// - Releasing pins needs mode and clock select both at 00H.
// - Master: clock pin direction 0 and clock pin latch 1.
// - Data out: direction bit and latch both 0.
// - External clock and data in: those direction bits set to 1.
//
// Design decision made here: the plain strobed port.
`default_nettype none
module tspc_host #(
   parameter int unsigned PRS_HZ = tspc_pkg::PRS_HZ_DEF
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [tspc_pkg::HOST_AW-1:0] host_addr,
   input wire logic [tspc_pkg::DW-1:0] host_wdata,
   input wire logic host_wr,
   input wire logic host_rd,
   output logic [tspc_pkg::DW-1:0] host_rdata,
   output logic [tspc_pkg::DEV_AW-1:0] dev_addr,
   output logic [tspc_pkg::DW-1:0] dev_wdata,
   output logic dev_wr,
   output logic dev_rd,
   input wire logic [tspc_pkg::DW-1:0] dev_rdata,
   input wire logic dev_stop,
   output logic slv_sclk,
   output logic slv_sclk_oe
);
   import tspc_pkg::*;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   typedef struct packed {
      tspc_state_type st;
      tspc_state_type nxt;
      logic [DEV_AW-1:0] bus_addr;
      logic [DW-1:0] bus_wdata;
      logic bus_wr;
      logic bus_rd;
      logic [DW-1:0] hrdata;
      logic [DW-1:0] cfg;
      logic [DW-1:0] tx;
      logic [DW-1:0] rx;
      logic [DW-1:0] div;
      logic [DW-1:0] last_mode;
      logic done;
      logic err;
      logic cfgd;
      logic devb;
      logic gen;
      logic [2:0] sync;
      logic stop;
   } tspc_host_state_type;

   tspc_host_state_type q;
   tspc_host_state_type d;

   logic gen_done;
   logic gen_busy;
   logic gen_sclk;
   logic [DW-1:0] mode_val;
   logic [DW-1:0] clk_val;
   logic [DW-1:0] dir_val;
   logic [DW-1:0] lat_val;
   logic [DW-1:0] stat_val;
   logic [CKS_W-1:0] cks;
   logic slave_cfg;
   logic trmd_cfg;
   logic idle;
   logic rel_go;
   logic set_done;
   logic set_err;
   logic clr_done;
   logic clr_err;
   logic [2:0] cmd;

   // Device register images built from the host configuration
   always_comb begin
      cks = q.cfg[CFG_CKS +: CKS_W];
      slave_cfg = (cks == CKS_SLAVE);
      trmd_cfg = q.cfg[CFG_TRMD];
      mode_val = REG_ZERO;
      mode_val[MODE_TRMD_BIT] = trmd_cfg;
      mode_val[MODE_DIR_BIT] = q.cfg[CFG_LSB];
      clk_val = REG_ZERO;
      clk_val[CK_CKP_BIT] = q.cfg[CFG_CKP];
      clk_val[CK_DAP_BIT] = q.cfg[CFG_DAP];
      clk_val[CKS_W-1:0] = cks;
      dir_val = DIR_RESET;
      dir_val[PIN_CLK] = slave_cfg;
      dir_val[PIN_DOUT] = ~trmd_cfg;
      lat_val = REG_ZERO;
      lat_val[PIN_CLK] = 1'b1;
      stat_val = REG_ZERO;
      stat_val[ST_BUSY] = (q.st != S_IDLE);
      stat_val[ST_DONE] = q.done;
      stat_val[ST_ERR] = q.err;
      stat_val[ST_DEVB] = q.devb;
      stat_val[ST_CFGD] = q.cfgd;
      stat_val[ST_STOP] = q.stop;
   end

   // Sequencer, host register slave and stop-level synchroniser
   always_comb begin
      d = q;
      d.bus_wr = 1'b0;
      d.bus_rd = 1'b0;
      d.gen = 1'b0;
      d.hrdata = REG_ZERO;
      idle = (q.st == S_IDLE);
      rel_go = 1'b0;
      set_done = 1'b0;
      set_err = 1'b0;
      clr_done = 1'b0;
      clr_err = 1'b0;
      cmd = 3'h0;
      // Stop level counts only when the last two stages agree
      d.sync = {q.sync[1:0], dev_stop};
      if (q.sync[1] == q.sync[2]) begin
         d.stop = q.sync[2];
      end
      // Host writes; settings are locked while a sequence runs
      if (host_wr) begin
         if (host_addr == H_CMD) begin
            cmd = host_wdata[2:0];
         end else if (host_addr == H_CFG) begin
            if (idle) d.cfg = host_wdata;
            else set_err = 1'b1;
         end else if (host_addr == H_TX) begin
            if (idle) d.tx = host_wdata;
            else set_err = 1'b1;
         end else if (host_addr == H_DIV) begin
            if (idle) d.div = host_wdata;
            else set_err = 1'b1;
         end else if (host_addr == H_STAT) begin
            clr_done = host_wdata[ST_DONE];
            clr_err = host_wdata[ST_ERR];
         end
      end
      // Host reads answer in the next cycle only
      if (host_rd) begin
         if (host_addr == H_CFG) d.hrdata = q.cfg;
         else if (host_addr == H_TX) d.hrdata = q.tx;
         else if (host_addr == H_RX) d.hrdata = q.rx;
         else if (host_addr == H_STAT) d.hrdata = stat_val;
         else if (host_addr == H_DIV) d.hrdata = q.div;
      end
      if (!idle && (cmd != 3'h0)) begin
         set_err = 1'b1;
      end
      case (q.st)
         S_IDLE: begin
            if (cmd[CMD_CFG]) begin
               if (!tspc_speed_ok(cks, PRS_HZ) || (slave_cfg && (q.div < SLV_DIV_MIN))) begin
                  set_err = 1'b1;
               end else begin
                  // Disable first so clock select is written with enable low
                  d.bus_wr = 1'b1;
                  d.bus_addr = MODE_ADDR;
                  d.bus_wdata = REG_ZERO;
                  d.cfgd = 1'b0;
                  d.st = S_CLK;
               end
            end else if (cmd[CMD_XFER]) begin
               if (!q.cfgd || (slave_cfg && q.stop)) begin
                  set_err = 1'b1;
               end else if (trmd_cfg) begin
                  d.bus_wr = 1'b1;
                  d.bus_addr = TXBUF_ADDR;
                  d.bus_wdata = q.tx;
                  d.st = S_WAIT;
                  d.nxt = S_GET;
               end else begin
                  d.bus_rd = 1'b1;
                  d.bus_addr = SHIFT_ADDR;
                  d.st = S_WAIT;
                  d.nxt = S_GET;
               end
            end else if (cmd[CMD_REL]) begin
               rel_go = 1'b1;
               d.bus_wr = 1'b1;
               d.bus_addr = MODE_ADDR;
               d.bus_wdata = REG_ZERO;
               d.cfgd = 1'b0;
               d.st = S_REL;
            end
         end
         S_CLK: begin
            d.bus_wr = 1'b1;
            d.bus_addr = CLKSEL_ADDR;
            d.bus_wdata = clk_val;
            d.st = S_LAT;
         end
         S_LAT: begin
            // Latch before direction so the pin never drives a stale level
            d.bus_wr = 1'b1;
            d.bus_addr = LATCH_ADDR;
            d.bus_wdata = lat_val;
            d.st = S_DIR;
         end
         S_DIR: begin
            d.bus_wr = 1'b1;
            d.bus_addr = DIR_ADDR;
            d.bus_wdata = dir_val;
            d.st = S_MODE;
         end
         S_MODE: begin
            d.bus_wr = 1'b1;
            d.bus_addr = MODE_ADDR;
            d.bus_wdata = mode_val;
            d.st = S_EN;
         end
         S_EN: begin
            d.bus_wr = 1'b1;
            d.bus_addr = MODE_ADDR;
            d.bus_wdata = mode_val;
            d.bus_wdata[MODE_EN_BIT] = 1'b1;
            d.cfgd = 1'b1;
            set_done = 1'b1;
            d.st = S_IDLE;
         end
         S_REL: begin
            d.bus_wr = 1'b1;
            d.bus_addr = CLKSEL_ADDR;
            d.bus_wdata = REG_ZERO;
            set_done = 1'b1;
            d.st = S_IDLE;
         end
         S_WAIT: begin
            // Bus strobe is out now; read data arrive next cycle
            d.st = q.nxt;
         end
         S_GET: begin
            if (!trmd_cfg) begin
               d.rx = dev_rdata;
            end
            if (slave_cfg) begin
               d.gen = 1'b1;
               d.st = S_GEN;
            end else begin
               d.bus_rd = 1'b1;
               d.bus_addr = MODE_ADDR;
               d.st = S_WAIT;
               d.nxt = S_PGET;
            end
         end
         S_GEN: begin
            if (gen_done) begin
               d.bus_rd = 1'b1;
               d.bus_addr = MODE_ADDR;
               d.st = S_WAIT;
               d.nxt = S_PGET;
            end
         end
         S_PGET: begin
            d.devb = dev_rdata[MODE_BUSY_BIT];
            d.bus_rd = 1'b1;
            d.st = S_WAIT;
            if (dev_rdata[MODE_BUSY_BIT]) begin
               d.bus_addr = MODE_ADDR;
               d.nxt = S_PGET;
            end else if (trmd_cfg) begin
               // In receive mode this read would start another byte
               d.bus_addr = SHIFT_ADDR;
               d.nxt = S_DGET;
            end else begin
               d.bus_rd = 1'b0;
               set_done = 1'b1;
               d.st = S_IDLE;
            end
         end
         S_DGET: begin
            d.rx = dev_rdata;
            set_done = 1'b1;
            d.st = S_IDLE;
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase
      // Shadow of the mode value last sent to the device
      if (d.bus_wr && (d.bus_addr == MODE_ADDR)) begin
         d.last_mode = d.bus_wdata;
      end
      // Set wins over a clear in the same cycle
      d.done = (q.done & ~clr_done) | set_done;
      d.err = (q.err & ~clr_err) | set_err;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   tspc_sclk_gen #(
      .BITS(BITS_PER_XFER)
   ) u_gen (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .start(q.gen),
      .half_div(q.div),
      .idle_level(q.cfg[CFG_CKP]),
      .sclk(gen_sclk),
      .busy(gen_busy),
      .done(gen_done)
   );

   // Strobes gated so a frozen cycle never repeats an access
   assign dev_wr = q.bus_wr & ce;
   assign dev_rd = q.bus_rd & ce;
   assign dev_addr = q.bus_addr;
   assign dev_wdata = q.bus_wdata;
   assign host_rdata = q.hrdata;
   assign slv_sclk = gen_sclk;
   assign slv_sclk_oe = q.cfgd & slave_cfg;

   logic mode_wr;
   logic clk_wr;
   logic dir_wr;
   logic lat_wr;
   logic [DW-1:0] last_mode;
   assign mode_wr = dev_wr && (dev_addr == MODE_ADDR);
   assign clk_wr = dev_wr && (dev_addr == CLKSEL_ADDR);
   assign dir_wr = dev_wr && (dev_addr == DIR_ADDR);
   assign lat_wr = dev_wr && (dev_addr == LATCH_ADDR);
   assign last_mode = q.last_mode;

   sequence s_mode_zero;
      mode_wr && (dev_wdata == REG_ZERO);
   endsequence
   sequence s_clk_zero;
      clk_wr && (dev_wdata == REG_ZERO);
   endsequence

   property p_no_mode_busy;
      mode_wr |-> !q.devb && !(q.st inside {S_WAIT, S_GET, S_GEN, S_PGET, S_DGET});
   endproperty
   a_no_mode_busy: assert property (p_no_mode_busy) else $error("mode written during transfer");

   // Enabling write keeps the order set up while the port was stopped
   property p_order_hold;
      (mode_wr && dev_wdata[MODE_EN_BIT])
         |-> !$past(last_mode[MODE_EN_BIT]) && (dev_wdata[MODE_DIR_BIT] == $past(last_mode[MODE_DIR_BIT]));
   endproperty
   a_order_hold: assert property (p_order_hold) else $error("order changed while enabled");

   property p_bit5_zero;
      mode_wr |-> !dev_wdata[MODE_RSVD_BIT];
   endproperty
   a_bit5_zero: assert property (p_bit5_zero) else $error("mode bit 5 written as one");

   // Checked at enable: the all-zero release image never runs a clock
   property p_speed;
      (mode_wr && dev_wdata[MODE_EN_BIT]) |-> tspc_speed_ok(cks, PRS_HZ) && (!slave_cfg || (q.div >= SLV_DIV_MIN));
   endproperty
   a_speed: assert property (p_speed) else $error("serial clock above limit");

   property p_clk_disabled;
      clk_wr |-> !last_mode[MODE_EN_BIT] && !$past(last_mode[MODE_EN_BIT]);
   endproperty
   a_clk_disabled: assert property (p_clk_disabled) else $error("clock select written while enabled");

   property p_no_stop_start;
      (q.gen && ce) |-> !q.stop;
   endproperty
   a_no_stop_start: assert property (p_no_stop_start) else $error("slave clock started in stop");

   property p_release;
      (rel_go && ce) ##1 ce |-> s_mode_zero ##1 (!ce or s_clk_zero);
   endproperty
   a_release: assert property (p_release) else $error("release did not zero both registers");

   property p_master_clk;
      lat_wr |-> dev_wdata[PIN_CLK] ##1 (!ce or (dir_wr && (dev_wdata[PIN_CLK] == slave_cfg)));
   endproperty
   a_master_clk: assert property (p_master_clk) else $error("clock pin set up wrongly");

   property p_dout_pin;
      (lat_wr |-> !dev_wdata[PIN_DOUT]) and ((dir_wr && trmd_cfg) |-> !dev_wdata[PIN_DOUT]);
   endproperty
   a_dout_pin: assert property (p_dout_pin) else $error("data out pin not cleared");

   property p_slave_inputs;
      (dir_wr && slave_cfg) |-> dev_wdata[PIN_CLK] && dev_wdata[PIN_DIN];
   endproperty
   a_slave_inputs: assert property (p_slave_inputs) else $error("slave pins not inputs");
endmodule // tspc_host
`default_nettype wire

// ---- core/tspc_pkg.sv ----
// Shared constants, types and helpers for the serial port host controller
`default_nettype none
package tspc_pkg;
   // Device register bus
   localparam int unsigned DEV_AW = 16;
   localparam int unsigned DW = 8;
   localparam logic [DEV_AW-1:0] MODE_ADDR = 16'hFF80;
   localparam logic [DEV_AW-1:0] CLKSEL_ADDR = 16'hFF81;
   localparam logic [DEV_AW-1:0] TXBUF_ADDR = 16'hFF82;
   localparam logic [DEV_AW-1:0] SHIFT_ADDR = 16'hFF83;
   localparam logic [DEV_AW-1:0] DIR_ADDR = 16'hFF21;
   localparam logic [DEV_AW-1:0] LATCH_ADDR = 16'hFF01;

   // Mode register fields
   localparam int unsigned MODE_EN_BIT = 7;
   localparam int unsigned MODE_TRMD_BIT = 6;
   localparam int unsigned MODE_RSVD_BIT = 5;
   localparam int unsigned MODE_DIR_BIT = 4;
   localparam int unsigned MODE_BUSY_BIT = 0;

   // Clock select register fields
   localparam int unsigned CK_CKP_BIT = 4;
   localparam int unsigned CK_DAP_BIT = 3;
   localparam int unsigned CKS_W = 3;
   localparam logic [CKS_W-1:0] CKS_SLAVE = 3'h7;

   // Port 1 pin positions and reset values
   localparam int unsigned PIN_CLK = 0;
   localparam int unsigned PIN_DIN = 1;
   localparam int unsigned PIN_DOUT = 2;
   localparam logic [DW-1:0] REG_ZERO = 8'h00;
   localparam logic [DW-1:0] DIR_RESET = 8'hFF;

   // Host register offsets
   localparam int unsigned HOST_AW = 3;
   localparam logic [HOST_AW-1:0] H_CMD = 3'h0;
   localparam logic [HOST_AW-1:0] H_CFG = 3'h1;
   localparam logic [HOST_AW-1:0] H_TX = 3'h2;
   localparam logic [HOST_AW-1:0] H_RX = 3'h3;
   localparam logic [HOST_AW-1:0] H_STAT = 3'h4;
   localparam logic [HOST_AW-1:0] H_DIV = 3'h5;

   // Host register fields
   localparam int unsigned CMD_CFG = 0;
   localparam int unsigned CMD_XFER = 1;
   localparam int unsigned CMD_REL = 2;
   localparam int unsigned CFG_TRMD = 0;
   localparam int unsigned CFG_LSB = 1;
   localparam int unsigned CFG_CKP = 2;
   localparam int unsigned CFG_DAP = 3;
   localparam int unsigned CFG_CKS = 4;
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_DONE = 1;
   localparam int unsigned ST_ERR = 2;
   localparam int unsigned ST_DEVB = 3;
   localparam int unsigned ST_CFGD = 4;
   localparam int unsigned ST_STOP = 5;

   // Clock rates and limits
   localparam int unsigned SYS_CLK_HZ = 40_000_000;
   localparam int unsigned MAX_SCLK_HZ = 5_000_000;
   localparam int unsigned PRS_HZ_DEF = 10_000_000;
   localparam logic [DW-1:0] SLV_DIV_MIN = DW'((SYS_CLK_HZ + 2 * MAX_SCLK_HZ - 1) / (2 * MAX_SCLK_HZ) - 1);
   localparam int unsigned BITS_PER_XFER = 8;

   typedef enum logic [3:0] {
      S_IDLE, S_CLK, S_LAT, S_DIR, S_MODE, S_EN, S_REL, S_WAIT, S_GET, S_GEN, S_PGET, S_DGET
   } tspc_state_type;

   // Divided master clock must stay at or below the serial limit
   function automatic logic tspc_speed_ok(input logic [CKS_W-1:0] cks, input int unsigned prs);
      return (cks == CKS_SLAVE) || ((prs >> (int'(cks) + 1)) <= MAX_SCLK_HZ);
   endfunction
endpackage
`default_nettype wire

// ---- core/tspc_sclk_gen.sv ----
// Serial clock generator for driving the device in slave mode
`default_nettype none
module tspc_sclk_gen #(
   parameter int unsigned BITS = tspc_pkg::BITS_PER_XFER
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic start,
   input wire logic [tspc_pkg::DW-1:0] half_div,
   input wire logic idle_level,
   output logic sclk,
   output logic busy,
   output logic done
);
   import tspc_pkg::*;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   localparam int unsigned TW = $clog2(2 * BITS + 1);
   localparam logic [TW-1:0] LAST_TOG = TW'(2 * BITS - 1);

   typedef struct packed {
      logic act;
      logic lvl;
      logic done;
      logic [DW-1:0] cnt;
      logic [TW-1:0] tog;
   } tspc_gen_state_type;

   tspc_gen_state_type q;
   tspc_gen_state_type d;

   // Two toggles per period, idle level restored after the last one
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (start && !q.act) begin
         d.act = 1'b1;
         d.cnt = half_div;
         d.lvl = idle_level;
         d.tog = '0;
      end else if (q.act) begin
         if (q.cnt == '0) begin
            d.cnt = half_div;
            d.lvl = ~q.lvl;
            d.tog = q.tog + TW'(1);
            if (q.tog == LAST_TOG) begin
               d.act = 1'b0;
               d.done = 1'b1;
            end
         end else begin
            d.cnt = q.cnt - 8'h01;
         end
      end else begin
         d.lvl = idle_level;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign sclk = q.lvl;
   assign busy = q.act;
   assign done = q.done;

   // Helper: periods seen since start, counted on leaving the idle level
   logic [TW-1:0] periods_q;
   logic lvl_prev_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         periods_q <= '0;
         lvl_prev_q <= 1'b0;
      end else if (ce) begin
         lvl_prev_q <= q.lvl;
         if (start && !q.act) begin
            periods_q <= '0;
         end else if (q.act && (q.lvl != lvl_prev_q) && (q.lvl != idle_level)) begin
            periods_q <= periods_q + TW'(1);
         end
      end
   end

   property p_eight_periods;
      done |-> (periods_q == TW'(BITS)) && (sclk == idle_level);
   endproperty
   a_eight_periods: assert property (p_eight_periods) else $error("wrong period count");

   property p_start_busy;
      (start && !busy && ce) |=> busy;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("generator did not start");
endmodule // tspc_sclk_gen
`default_nettype wire
